//--- inc/lsd_pkg.sv
// lsd_pkg: constants, register map and carrier types of the delay config
// block. Assumes one user (lsd_core) plus a bench that reads the same map.
`default_nettype none

package lsd_pkg;

   // ==========================================================
   // register map, byte offsets on the two-wire control link
   localparam logic [7:0] LSD_OFS_CTRL    = 8'h01; // mute_and_format_control
   localparam logic [7:0] LSD_OFS_RDLY_HI = 8'h02; // right_delay_high
   localparam logic [7:0] LSD_OFS_RDLY_LO = 8'h03; // right_delay_low
   localparam logic [7:0] LSD_OFS_LDLY_HI = 8'h04; // left_delay_high
   localparam logic [7:0] LSD_OFS_LDLY_LO = 8'h05; // left_delay_low
   localparam logic [7:0] LSD_OFS_FRAME   = 8'h06; // video_frame_delay
   localparam logic [7:0] LSD_OFS_PKTLEN  = 8'h07; // justified_word_length
   localparam logic [7:0] LSD_OFS_COMMIT  = 8'h08; // settings_commit
   localparam logic [7:0] LSD_REG_RESET   = 8'h00;

   // ==========================================================
   // field positions
   localparam int LSD_CTRL_MUTE_L  = 6;  // 01 mutes left
   localparam int LSD_CTRL_MUTE_R  = 7;  // 10 mutes right
   localparam int LSD_FRM_EN       = 7;
   localparam int LSD_FRM_RATE     = 6;
   localparam int LSD_FRM_FS_LSB   = 3;
   localparam int LSD_COMMIT_BIT   = 0;
   localparam int LSD_DLY_HI_BITS  = 5;

   // ==========================================================
   // limits and slave address
   localparam logic [12:0] LSD_DELAY_MAX  = 13'h1FFF; // 8191 samples
   localparam logic [4:0]  LSD_PKT_MAX    = 5'h18;    // 24 bits
   localparam logic [3:0]  LSD_ADDR_FIXED = 4'hD;     // 1101

   // sample rate per code in Hz, frame rate in centihertz
   localparam int unsigned LSD_FS_HZ [8] = '{32000, 44100, 48000, 88200,
                                             96000, 176400, 192000, 192000};
   localparam int unsigned LSD_RATE_CHZ [2] = '{5000, 5994};
   localparam int unsigned LSD_CHZ_PER_HZ   = 100;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      LSD_FMT_I2S,
      LSD_FMT_RIGHT,
      LSD_FMT_LJ,
      LSD_FMT_BYPASS
   } lsd_fmt_t;

   typedef enum logic [2:0] {
      LSD_ST_IDLE,
      LSD_ST_ADDR,
      LSD_ST_REG,
      LSD_ST_WDATA,
      LSD_ST_RDATA
   } lsd_i2c_st_t;

   // settings handed to the delay engine on commit
   typedef struct packed {
      lsd_fmt_t    fmt;
      logic [12:0] delay_l;
      logic [12:0] delay_r;
      logic [4:0]  pkt_len;
   } lsd_cfg_t;

endpackage : lsd_pkg

`default_nettype wire

//--- core/lsd_core.sv
// lsd_core: two-wire register file, commit logic and engine-side mute hold
// of the stereo lip-sync delay. Assumes mclk (40 MHz) is free running and
// bclk comes from the audio source; the delay memory sits outside.
`default_nettype none

// Operation
// - eight byte registers 0x01-0x08, reset zero
// - ctrl bits 7:6 mute left/right/both
// - ctrl bits 1:0 select I2S, right, left justified
// - format code 11 is bypass, zero delay
// - 13-bit delay from 5-bit high, 8-bit low
// - delay value counts sample periods, zero none
// - per-channel delay up to 8191 samples
// - frame bit 7 picks frame over sample delay
// - frame bit 6: 50 Hz or 59.94 Hz
// - frame bits 5:3 encode sample rate
// - frame bits 2:0 give frames minus one
// - frame delay is int(frames*fs/rate)
// - frame delay saturates at 8191
// - packet length bits 5:0, right-justified only
// - packet length above 24 reads as 24
// - commit bit 0 moves settings to engine
// - channel muted until new delay has passed
// - mute bits act without any commit
// - audio data sampled on rising bit clock
// - word select polarity depends on format
// - slave address is 1101 plus pin levels
// - register pointer auto-increments per byte
module lsd_core (
   input  wire  logic              mclk,
   input  wire  logic              rst_n,
   input  wire  logic              scl_in,
   input  wire  logic              sda_in,
   output var   logic              sda_out,
   output var   logic              sda_oe_n,
   input  wire  logic              addr_select_lsb,
   input  wire  logic              addr_select_mid,
   input  wire  logic              addr_select_msb,
   input  wire  logic              bclk,
   input  wire  logic              lrclk,
   input  wire  logic              audio_data,
   output var   logic              eng_data,
   output var   logic              eng_ws,
   output var   lsd_pkg::lsd_cfg_t eng_cfg,
   output var   logic              eng_load,
   output var   logic              eng_mute_l,
   output var   logic              eng_mute_r
);

   // ==========================================================
   // pin synchronisers (mclk)
   logic [2:0] scl_sync_r, sda_sync_r; // [0] only feeds [1]
   logic [2:0] adr_s1_r, adr_s2_r;
   logic       scl_rise, scl_fall, bus_start, bus_stop;

   // third stage is only a delayed copy for edge detection
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], scl_in};
         sda_sync_r <= {sda_sync_r[1:0], sda_in};
      end
   end

   // strap pins also pass two flops, they may move at any time
   always_ff @(posedge mclk) begin
      adr_s1_r <= {addr_select_msb, addr_select_mid, addr_select_lsb};
      adr_s2_r <= adr_s1_r;
   end

   assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
   assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
   assign bus_start = scl_sync_r[1] & ~sda_sync_r[1] & sda_sync_r[2];
   assign bus_stop  = scl_sync_r[1] & sda_sync_r[1] & ~sda_sync_r[2];

   // ==========================================================
   // two-wire slave
   lsd_pkg::lsd_i2c_st_t st_r;
   logic [3:0]  bit_cnt_r;
   logic [7:0]  shift_r;
   logic        ack_slot_r;
   logic [7:0]  ptr_r;
   logic [7:0]  reg_file_r [1:8];
   logic [7:0]  rd_byte;
   logic        byte_done, addr_hit, wr_strobe, commit_pulse;

   assign byte_done = scl_fall & ~ack_slot_r & (bit_cnt_r == 4'h8);
   assign addr_hit  = (shift_r[7:1] == {lsd_pkg::LSD_ADDR_FIXED,
                                        adr_s2_r});
   assign wr_strobe = byte_done & (st_r == lsd_pkg::LSD_ST_WDATA);
   assign commit_pulse = wr_strobe & (ptr_r == lsd_pkg::LSD_OFS_COMMIT)
                         & shift_r[lsd_pkg::LSD_COMMIT_BIT];

   // unmapped offsets read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      if (ofs >= lsd_pkg::LSD_OFS_CTRL && ofs <= lsd_pkg::LSD_OFS_COMMIT) begin
         v = reg_file_r[ofs[3:0]];
      end
      return v;
   endfunction

   assign rd_byte = reg_read(ptr_r);

   // bit engine: sample on scl rise, drive on scl fall
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r       <= lsd_pkg::LSD_ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         ack_slot_r <= 1'b0;
         ptr_r      <= 8'h00;
         sda_oe_n   <= 1'b1;
      end else if (bus_start) begin
         st_r       <= lsd_pkg::LSD_ST_ADDR;
         bit_cnt_r  <= 4'h0;
         ack_slot_r <= 1'b0;
         sda_oe_n   <= 1'b1;
      end else if (bus_stop) begin
         st_r       <= lsd_pkg::LSD_ST_IDLE;
         ack_slot_r <= 1'b0;
         sda_oe_n   <= 1'b1;
      end else if (st_r != lsd_pkg::LSD_ST_IDLE) begin
         if (scl_rise) begin
            if (ack_slot_r) begin
               // master nack ends a read burst
               if (st_r == lsd_pkg::LSD_ST_RDATA && sda_sync_r[1]) begin
                  st_r <= lsd_pkg::LSD_ST_IDLE;
               end
            end else begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (st_r != lsd_pkg::LSD_ST_RDATA) begin
                  shift_r <= {shift_r[6:0], sda_sync_r[1]};
               end
            end
         end else if (byte_done) begin
            ack_slot_r <= 1'b1;
            bit_cnt_r  <= 4'h0;
            case (st_r)
               lsd_pkg::LSD_ST_ADDR: begin
                  if (addr_hit) begin
                     sda_oe_n <= 1'b0;
                     st_r <= shift_r[0] ? lsd_pkg::LSD_ST_RDATA
                                        : lsd_pkg::LSD_ST_REG;
                  end else begin
                     st_r <= lsd_pkg::LSD_ST_IDLE;
                  end
               end
               lsd_pkg::LSD_ST_REG: begin
                  sda_oe_n <= 1'b0;
                  ptr_r    <= shift_r;
                  st_r     <= lsd_pkg::LSD_ST_WDATA;
               end
               lsd_pkg::LSD_ST_WDATA: begin
                  sda_oe_n <= 1'b0;
                  ptr_r    <= ptr_r + 8'h01;
               end
               default: begin
                  sda_oe_n <= 1'b1; // master acks a read byte
                  ptr_r    <= ptr_r + 8'h01;
               end
            endcase
         end else if (scl_fall && ack_slot_r) begin
            ack_slot_r <= 1'b0;
            if (st_r == lsd_pkg::LSD_ST_RDATA) begin
               shift_r  <= rd_byte;
               sda_oe_n <= rd_byte[7];
            end else begin
               sda_oe_n <= 1'b1;
            end
         end else if (scl_fall && st_r == lsd_pkg::LSD_ST_RDATA) begin
            shift_r  <= {shift_r[6:0], 1'b0};
            sda_oe_n <= shift_r[6];
         end
      end
   end

   // the pin only ever pulls low
   always_ff @(posedge mclk) begin
      sda_out <= 1'b0;
   end

   // register file; spare ctrl bits 5:2 kept as written
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 1; i <= 8; i++) begin
            reg_file_r[i] <= lsd_pkg::LSD_REG_RESET;
         end
      end else if (wr_strobe && ptr_r >= lsd_pkg::LSD_OFS_CTRL
                   && ptr_r <= lsd_pkg::LSD_OFS_COMMIT) begin
         reg_file_r[ptr_r[3:0]] <= shift_r;
      end
   end

   // ==========================================================
   // commit: frame math, clamps, shadow word
   function automatic logic [12:0] frame_samples(input logic [7:0] fd);
      int unsigned num, quo;
      num = (32'(fd[2:0]) + 32'd1)
            * lsd_pkg::LSD_FS_HZ[fd[5:3]]
            * lsd_pkg::LSD_CHZ_PER_HZ;
      quo = num / lsd_pkg::LSD_RATE_CHZ[fd[lsd_pkg::LSD_FRM_RATE]];
      if (quo > 32'(lsd_pkg::LSD_DELAY_MAX)) begin
         quo = 32'(lsd_pkg::LSD_DELAY_MAX);
      end
      return quo[12:0];
   endfunction

   lsd_pkg::lsd_cfg_t cfg_nxt, shadow_r;
   logic [7:0]  frame_reg;
   logic [12:0] frame_val;
   logic [5:0]  pkt_raw;
   logic        commit_tgl_r;

   assign frame_reg = reg_file_r[lsd_pkg::LSD_OFS_FRAME[3:0]];
   assign frame_val = frame_samples(frame_reg);
   assign pkt_raw   = reg_file_r[lsd_pkg::LSD_OFS_PKTLEN[3:0]][5:0];

   // build engine settings from the register file
   always_comb begin
      cfg_nxt.fmt = lsd_pkg::lsd_fmt_t'(
                    reg_file_r[lsd_pkg::LSD_OFS_CTRL[3:0]][1:0]);
      cfg_nxt.delay_r = {reg_file_r[lsd_pkg::LSD_OFS_RDLY_HI[3:0]]
                         [lsd_pkg::LSD_DLY_HI_BITS-1:0],
                         reg_file_r[lsd_pkg::LSD_OFS_RDLY_LO[3:0]]};
      cfg_nxt.delay_l = {reg_file_r[lsd_pkg::LSD_OFS_LDLY_HI[3:0]]
                         [lsd_pkg::LSD_DLY_HI_BITS-1:0],
                         reg_file_r[lsd_pkg::LSD_OFS_LDLY_LO[3:0]]};
      if (frame_reg[lsd_pkg::LSD_FRM_EN]) begin
         cfg_nxt.delay_r = frame_val;
         cfg_nxt.delay_l = frame_val;
      end
      if (cfg_nxt.fmt == lsd_pkg::LSD_FMT_BYPASS) begin
         cfg_nxt.delay_r = 13'h0000;
         cfg_nxt.delay_l = 13'h0000;
      end
      if (pkt_raw > 6'(lsd_pkg::LSD_PKT_MAX)) begin
         cfg_nxt.pkt_len = lsd_pkg::LSD_PKT_MAX;
      end else begin
         cfg_nxt.pkt_len = pkt_raw[4:0];
      end
   end

   // shadow stays still between commits so bclk can sample it whole;
   // two commits closer than a few bclk periods may lose the first
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shadow_r     <= '0;
         commit_tgl_r <= 1'b0;
      end else if (commit_pulse) begin
         shadow_r     <= cfg_nxt;
         commit_tgl_r <= ~commit_tgl_r;
      end
   end

   // ==========================================================
   // bclk domain: settings load, mute hold, sampling
   logic [1:0]  brst_r;
   logic        brst_n;
   logic [2:0]  tgl_sync_r;
   logic [1:0]  mute_s1_r, mute_s2_r;
   logic        ws_prev_r, hold_l_r, hold_r_r;
   logic [12:0] cnt_l_r, cnt_r_r;
   logic        load_now, ws_rise, ws_fall;
   logic        left_done, right_done, is_i2s;

   // mclk reset carried over as a level
   always_ff @(posedge bclk) begin
      brst_r <= {brst_r[0], rst_n};
   end
   assign brst_n = brst_r[1];

   always_ff @(posedge bclk) begin
      if (!brst_n) begin
         tgl_sync_r <= 3'h0;
         mute_s1_r  <= 2'h0;
         mute_s2_r  <= 2'h0;
      end else begin
         tgl_sync_r <= {tgl_sync_r[1:0], commit_tgl_r};
         mute_s1_r  <= {reg_file_r[lsd_pkg::LSD_OFS_CTRL[3:0]]
                        [lsd_pkg::LSD_CTRL_MUTE_R],
                        reg_file_r[lsd_pkg::LSD_OFS_CTRL[3:0]]
                        [lsd_pkg::LSD_CTRL_MUTE_L]};
         mute_s2_r  <= mute_s1_r;
      end
   end
   assign load_now = tgl_sync_r[1] ^ tgl_sync_r[2];

   // audio pins are on the bit clock already
   always_ff @(posedge bclk) begin
      eng_data  <= audio_data;
      eng_ws    <= lrclk;
      ws_prev_r <= eng_ws;
   end

   assign is_i2s     = (eng_cfg.fmt == lsd_pkg::LSD_FMT_I2S);
   assign ws_rise    = eng_ws & ~ws_prev_r;
   assign ws_fall    = ~eng_ws & ws_prev_r;
   assign left_done  = is_i2s ? ws_rise : ws_fall;
   assign right_done = is_i2s ? ws_fall : ws_rise;

   // settings load and one-cycle load pulse for the engine
   always_ff @(posedge bclk) begin
      if (!brst_n) begin
         eng_cfg  <= '0;
         eng_load <= 1'b0;
      end else begin
         eng_load <= load_now;
         if (load_now) begin
            eng_cfg <= shadow_r;
         end
      end
   end

   // count samples out of each channel after a commit
   always_ff @(posedge bclk) begin
      if (!brst_n) begin
         hold_l_r <= 1'b0;
         hold_r_r <= 1'b0;
         cnt_l_r  <= 13'h0000;
         cnt_r_r  <= 13'h0000;
      end else if (load_now) begin
         hold_l_r <= (shadow_r.delay_l != 13'h0000);
         hold_r_r <= (shadow_r.delay_r != 13'h0000);
         cnt_l_r  <= 13'h0000;
         cnt_r_r  <= 13'h0000;
      end else begin
         if (hold_l_r && left_done) begin
            cnt_l_r <= cnt_l_r + 13'h0001;
            if (cnt_l_r + 13'h0001 >= eng_cfg.delay_l) begin
               hold_l_r <= 1'b0;
            end
         end
         if (hold_r_r && right_done) begin
            cnt_r_r <= cnt_r_r + 13'h0001;
            if (cnt_r_r + 13'h0001 >= eng_cfg.delay_r) begin
               hold_r_r <= 1'b0;
            end
         end
      end
   end

   // register mute and commit hold, ored per channel
   always_ff @(posedge bclk) begin
      if (!brst_n) begin
         eng_mute_l <= 1'b0;
         eng_mute_r <= 1'b0;
      end else begin
         eng_mute_l <= mute_s2_r[0] | hold_l_r;
         eng_mute_r <= mute_s2_r[1] | hold_r_r;
      end
   end

   // ==========================================================
   // checks
   regs_reset_a: assert property (@(posedge mclk)
      !rst_n |=> reg_file_r[1] == 8'h00 && reg_file_r[8] == 8'h00)
      else $error("register not cleared by reset");
   mute_left_a: assert property (@(posedge bclk) disable iff (!brst_n)
      mute_s2_r[0] |=> eng_mute_l)
      else $error("left mute not applied");
   bypass_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      commit_pulse && cfg_nxt.fmt == lsd_pkg::LSD_FMT_BYPASS
      |=> shadow_r.delay_l == 13'h0000 && shadow_r.delay_r == 13'h0000)
      else $error("bypass carries a delay");
   frame_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      commit_pulse && frame_reg[7] && cfg_nxt.fmt != lsd_pkg::LSD_FMT_BYPASS
      |=> shadow_r.delay_l == $past(frame_val))
      else $error("frame delay not taken");
   pkt_clamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
      shadow_r.pkt_len <= 5'h18)
      else $error("packet length above 24");
   commit_move_a: assert property (@(posedge mclk) disable iff (!rst_n)
      commit_pulse |=> commit_tgl_r != $past(commit_tgl_r)
      ##[1:300] 1'b1)
      else $error("commit did not toggle");
   commit_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_strobe && ptr_r == 8'h08 && !shift_r[0]
      |=> $stable(commit_tgl_r) && $stable(shadow_r))
      else $error("zero commit changed settings");
   hold_mute_a: assert property (@(posedge bclk) disable iff (!brst_n)
      hold_r_r |=> eng_mute_r)
      else $error("right not muted during hold");
   addr_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
      byte_done && st_r == lsd_pkg::LSD_ST_ADDR && addr_hit
      && !bus_start && !bus_stop |=> !sda_oe_n)
      else $error("address not acknowledged");
   ptr_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_strobe && !bus_start && !bus_stop |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer did not advance");

endmodule // lsd_core

`default_nettype wire

//--- verification/lsd_ctl_model.sv
// lsd_ctl_model: two-wire bus controller and serial audio source.
// Assumes the bench resolves the open-drain data wire into sda_w.
`default_nettype none

module lsd_ctl_model (
   input  wire logic mclk,
   input  wire logic bclk,
   input  wire logic sda_w,
   output var  logic scl,
   output var  logic sda_m,
   output var  logic lrclk,
   output var  logic audio_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] bcnt_r = 5'h00;

   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
      lrclk = 1'b0;
      audio_data = 1'b0;
   end

   // ==========================================================
   // audio source
   // 32 bit clocks per word, more than any packet length
   always @(posedge bclk) begin
      bcnt_r <= bcnt_r + 5'h01;
      audio_data <= bcnt_r[0] ^ bcnt_r[3];
      if (bcnt_r == 5'h1F)
         lrclk <= ~lrclk;
   end

   // ==========================================================
   // two-wire controller
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // phases of 6+ mclk, well above the synchroniser delay
   task automatic bit_x(input logic b, output logic r);
      sda_m <= b;
      tick(6);
      scl <= 1'b1;
      tick(4);
      r = sda_w;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   // also serves as repeated start: data rises only while clock is low
   task automatic start();
      sda_m <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(6);
      sda_m <= 1'b0;
      tick(6);
      scl <= 1'b0;
      tick(2);
   endtask

   task automatic stop();
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(6);
      sda_m <= 1'b1;
      tick(6);
   endtask

   task automatic byte_x(input logic [7:0] d, input logic rel,
                         output logic [7:0] q, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], b);
         q[i] = b;
      end
      bit_x(rel, b);
      ack = ~b;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] ofs,
                     input logic [7:0] d[$], output logic ok);
      logic [7:0] q;
      logic       a;
      start();
      byte_x(adr, 1'b1, q, ok);
      byte_x(ofs, 1'b1, q, a);
      ok &= a;
      foreach (d[i]) begin
         byte_x(d[i], 1'b1, q, a);
         ok &= a;
      end
      stop();
   endtask

   // last byte gets a nack so the device lets go of the wire
   task automatic rd(input logic [7:0] adr, input logic [7:0] ofs,
                     input int n, output logic [7:0] q[$]);
      logic [7:0] b;
      logic       a;
      q = {};
      start();
      byte_x(adr, 1'b1, b, a);
      byte_x(ofs, 1'b1, b, a);
      start();
      byte_x(adr | 8'h01, 1'b1, b, a);
      for (int i = 0; i < n; i++) begin
         byte_x(8'hFF, i == n - 1, b, a);
         q.push_back(b);
      end
      stop();
   endtask
endmodule // lsd_ctl_model

`default_nettype wire

//--- verification/testbench.sv
// testbench: checks the delay config block over its two-wire link.
// Assumes lsd_pkg, lsd_core and lsd_ctl_model are compiled first.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] ADR = 8'hD2; // straps 001, write
   logic              mclk  = 1'b0;
   logic              bclk  = 1'b0;
   logic              rst_n = 1'b0;
   logic              run_r = 1'b0;
   logic [2:0]        asel  = 3'h1;
   logic [1:0]        prev_r = 2'h0;
   wire logic         scl, sda_m, sda_w, lrclk, audio_data;
   logic              sda_out, sda_oe_n, eng_data, eng_ws;
   logic              eng_load, eng_mute_l, eng_mute_r;
   lsd_pkg::lsd_cfg_t eng_cfg;
   int                miscompares = 0;
   int                checked = 0;
   int                loads = 0;
   int                cyc = 0;
   logic [7:0]        q[$];
   logic              ok;

   // bclk unrelated in phase to mclk
   always #12.5 mclk = ~mclk;
   always #16 bclk = ~bclk;
   // pull-up wins unless someone pulls low
   assign sda_w = sda_m & (sda_oe_n | sda_out);

   lsd_ctl_model i_ctl (.mclk(mclk), .bclk(bclk), .sda_w(sda_w),
      .scl(scl), .sda_m(sda_m), .lrclk(lrclk), .audio_data(audio_data));

   lsd_core i_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .addr_select_lsb(asel[0]), .addr_select_mid(asel[1]),
      .addr_select_msb(asel[2]), .bclk(bclk), .lrclk(lrclk),
      .audio_data(audio_data), .eng_data(eng_data), .eng_ws(eng_ws),
      .eng_cfg(eng_cfg), .eng_load(eng_load),
      .eng_mute_l(eng_mute_l), .eng_mute_r(eng_mute_r));

   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [32:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic bwait(input int n);
      repeat (n) @(posedge bclk);
   endtask

   task automatic wrq(input logic [7:0] ofs, input logic [7:0] d[$]);
      i_ctl.wr(ADR, ofs, d, ok);
      chk("ack", 33'(ok), 33'h1);
   endtask

   task automatic wr1(input logic [7:0] ofs, input logic [7:0] d);
      wrq(ofs, {d});
   endtask

   // commit lands a few bclk after its byte; the stop covers that
   task automatic commit();
      wr1(8'h08, 8'h01);
      bwait(8);
   endtask

   // pipe and commit-pulse monitor; tallies loads for the tests
   always @(posedge bclk) begin
      if (run_r)
         chk("pipe", {31'h0, eng_ws, eng_data}, {31'h0, prev_r});
      prev_r = {lrclk, audio_data};
      if (eng_load === 1'b1)
         loads++;
   end

   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ==========================================================
   // scenarios
   task automatic t_reset();
      i_ctl.rd(ADR, 8'h01, 8, q);
      foreach (q[i]) chk("rst_reg", 33'(q[i]), 33'h0);
      chk("rst_cfg", eng_cfg, 33'h0);
      $display("t_reset done");
   endtask

   task automatic t_regs();
      logic [7:0] e[$];
      e = {8'h3C, 8'h1F, 8'hAA, 8'h15, 8'h55, 8'h2B, 8'h3F, 8'h00};
      wrq(8'h01, e);
      wr1(8'h09, 8'h77);
      e.push_back(8'h00);
      i_ctl.rd(ADR, 8'h01, 9, q);
      foreach (e[i]) chk("reg", 33'(q[i]), 33'(e[i]));
      bwait(8);
      chk("no_load", 33'(loads), 33'h0);
      chk("cfg_kept", eng_cfg, 33'h0);
      $display("t_regs done");
   endtask

   // straps move the address; the old one must go unanswered
   task automatic t_addr();
      @(posedge mclk);
      asel <= 3'h3;
      repeat (6) @(posedge mclk);
      i_ctl.wr(ADR, 8'h01, {8'hC0}, ok);
      chk("nack", 33'(ok), 33'h0);
      i_ctl.wr(8'hD6, 8'h01, {8'h3C}, ok);
      chk("ack_new", 33'(ok), 33'h1);
      asel <= 3'h1;
      repeat (6) @(posedge mclk);
      i_ctl.rd(ADR, 8'h01, 1, q);
      chk("ctrl", 33'(q[0]), 33'h3C);
      $display("t_addr done");
   endtask

   task automatic t_mute();
      for (int m = 0; m < 4; m++) begin
         wr1(8'h01, {2'(m), 6'h00});
         bwait(8);
         chk("mute_l", 33'(eng_mute_l), 33'(m % 2));
         chk("mute_r", 33'(eng_mute_r), 33'(m / 2));
      end
      chk("no_load", 33'(loads), 33'h0);
      $display("t_mute done");
   endtask

   // right 2 samples, left 6; a sample period (two words) takes 64 bclk
   task automatic t_commit();
      wrq(8'h01, {8'h00, 8'h00, 8'h02, 8'h00, 8'h06});
      commit();
      chk("load", 33'(loads), 33'h1);
      chk("cfg", eng_cfg, {2'h0, 13'h0006, 13'h0002, 5'h18});
      chk("hold_l", 33'(eng_mute_l), 33'h1);
      chk("hold_r", 33'(eng_mute_r), 33'h1);
      bwait(256);
      chk("hold_l", 33'(eng_mute_l), 33'h1);
      chk("free_r", 33'(eng_mute_r), 33'h0);
      bwait(256);
      chk("free_l", 33'(eng_mute_l), 33'h0);
      $display("t_commit done");
   endtask

   task automatic t_fmt();
      wr1(8'h07, 8'h14);
      for (int f = 0; f < 4; f++) begin
         wr1(8'h01, 8'(f));
         commit();
         chk("fmt", 33'(eng_cfg.fmt), 33'(f));
         chk("pkt", 33'(eng_cfg.pkt_len), 33'h14);
      end
      chk("byp", 33'({eng_cfg.delay_l, eng_cfg.delay_r}), 33'h0);
      $display("t_fmt done");
   endtask

   // walks every rate code; only code 5 (3 frames at 176400 Hz) runs into the ceiling
   task automatic t_frame();
      int unsigned e;
      logic [12:0] x;
      logic [2:0]  k3;
      wr1(8'h01, 8'h00);
      for (int k = 0; k < 8; k++) begin
         k3 = 3'(k);
         e = (8 - k) * lsd_pkg::LSD_FS_HZ[k] * lsd_pkg::LSD_CHZ_PER_HZ
             / lsd_pkg::LSD_RATE_CHZ[k % 2];
         x = (e > 8191) ? 13'h1FFF : 13'(e);
         wr1(8'h06, {1'b1, k3[0], k3, 3'(7 - k)});
         commit();
         chk("frm_l", 33'(eng_cfg.delay_l), 33'(x));
         chk("frm_r", 33'(eng_cfg.delay_r), 33'(x));
      end
      wr1(8'h06, 8'h7F);
      commit();
      chk("smp_l", 33'(eng_cfg.delay_l), 33'h6);
      chk("smp_r", 33'(eng_cfg.delay_r), 33'h2);
      $display("t_frame done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      bwait(8);
      run_r <= 1'b1;
      t_reset();
      t_regs();
      t_addr();
      t_mute();
      t_commit();
      t_fmt();
      t_frame();
      report_and_stop();
   end
endmodule // testbench

`default_nettype wire
